/* File: hdl/qlops_top.sv */
// Purpose: Divide-by-4 quadrature LO generator with per-channel phase select
//          and the serial configuration port that programs it.
// Assumes: Serial port pins are sampled as synchronous inputs on ref_clk_i,
//          so SCLK must run at most a quarter of the 4x LO rate.
// Notes:   Quadrant of the code rotates the digital LO; the two low code bits
//          go to the analog interpolator as chan_fine_o.
`timescale 1ns/1ps
`default_nettype none
module qlops_top (
    input  wire logic                                    ref_clk_i,  // 4x LO clock
    input  wire logic                                    sys_rst_i,  // Sync pulse, high
    input  wire logic                                    sclk_i,     // Serial clock
    input  wire logic                                    csb_n_i,    // Serial select, low
    input  wire logic                                    sdio_i,     // Serial data in
    output logic                                         sdio_o,     // Serial data out
    output logic                                         sdio_oe_o,  // Drive enable
    output logic                                         lo_i_o,     // 0 degree LO
    output logic                                         lo_q_o,     // 90 degree LO
    output logic [qlops_pkg::NUM_CH-1:0]                 chan_i_o,   // Rotated I LO
    output logic [qlops_pkg::NUM_CH-1:0]                 chan_q_o,   // Rotated Q LO
    output logic [qlops_pkg::NUM_CH-1:0][1:0]            chan_fine_o,// Fine step
    output logic                                         ref_ext_o   // External ref
);
    import qlops_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Gray form of the divider count advanced by a number of quadrants;
    // bit 1 is the I phase, bit 0 the Q phase, which leads I by 90 degrees.
    function automatic logic [1:0] rot_phase(input logic [1:0] cnt,
                                             input logic [1:0] quad);
        logic [1:0] b;
        b = 2'(cnt + quad);
        return {b[1], b[1] ^ b[0]};
    endfunction

    // Upper code bits pick a whole quadrant of the digital LO
    function automatic logic [1:0] code_quad(input logic [CODE_W-1:0] code);
        return code[QUAD_LSB +: 2];
    endfunction

    // Lower code bits are the sub-quadrant step left to the analog side
    function automatic logic [1:0] code_fine(input logic [CODE_W-1:0] code);
        return code[PHASE_CODE_LSB +: 2];
    endfunction

    // Lowest selected channel wins; an empty mask reads as code zero
    function automatic logic [CODE_W-1:0] lowest_code(input qlops_state_t st);
        logic [CODE_W-1:0] code;
        logic              found;
        code  = CODE_RESET;
        found = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (st.chan_sel[c] && !found) begin
                code  = st.codes[c];
                found = 1'b1;
            end
        end
        return code;
    endfunction

    // Register readback; unmapped addresses read as zero
    function automatic logic [7:0] reg_read(input qlops_state_t st,
                                            input logic [ADDR_W-1:0] a);
        logic [7:0] d;
        d = READ_NONE;
        unique case (a)
            REG_CHAN_SEL: begin
                d = st.chan_sel;
            end
            REG_REF_SEL: begin
                d[REF_EXT_BIT] = st.ref_ext;
            end
            REG_DEMOD_PHASE_CODE: begin
                d[PHASE_CODE_LSB +: CODE_W] = lowest_code(st);
            end
            default: begin
                d = READ_NONE;
            end
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    qlops_state_t s;
    qlops_state_t next_s;

    logic                     sclk_rise;
    logic                     sclk_fall;
    logic [1:0]               next_div;
    logic [ADDR_W-1:0]        instr_addr;
    logic [DATA_W-1:0]        wr_data;

    always_comb begin
        next_s     = s;
        sclk_rise  = sclk_i & ~s.sclk_q;
        sclk_fall  = ~sclk_i & s.sclk_q;
        instr_addr = {s.shift[ADDR_W-2:0], sdio_i};
        wr_data    = {s.shift[DATA_W-2:0], sdio_i};

        // --------------------------------------------------------------
        // Divider
        // --------------------------------------------------------------
        // Only the sync pulse gives the count a known start; from power-up
        // alone it may sit in any of its four phases. [R12]
        // Free count by four; no other input touches it, so a register
        // write cannot slip its phase. [R1] [R13]
        next_div   = 2'(s.div + 2'h1);
        next_s.div = next_div;
        // Outputs are flops fed from the next count, so every LO edge is
        // set by the 4x clock alone and sits exactly two cycles apart;
        // input clock asymmetry never enters. [R2] [R3]
        {next_s.lo_i, next_s.lo_q} = rot_phase(next_div, 2'h0);
        for (int c = 0; c < NUM_CH; c++) begin
            // Same code, same quadrant, same flop timing for every channel;
            // a larger code advances the phase. [R4] [R5] [R6]
            {next_s.chan_i[c], next_s.chan_q[c]} =
                rot_phase(next_div, code_quad(s.codes[c]));
        end

        // --------------------------------------------------------------
        // Serial port
        // --------------------------------------------------------------
        // SCLK is oversampled on the 4x clock, so each SCLK phase must span
        // two or more clocks; rises past the last data bit are ignored, as
        // there is no streaming mode.
        next_s.sclk_q = sclk_i;
        if (csb_n_i) begin
            next_s.bit_cnt = '0;
            next_s.sdio_oe = 1'b0;
        end else begin
            if (sclk_rise && s.bit_cnt != CNT_W'(FRAME_BITS)) begin
                next_s.shift   = {s.shift[INSTR_BITS-2:0], sdio_i};
                next_s.bit_cnt = CNT_W'(s.bit_cnt + 1'b1);
                if (s.bit_cnt == CNT_W'(INSTR_BITS - 1)) begin
                    next_s.rw   = s.shift[INSTR_RW_BIT - 1];
                    next_s.addr = instr_addr;
                    // Read data waits in the top byte for the falling edges
                    next_s.shift = {reg_read(s, instr_addr), READ_NONE};
                end
                if (s.bit_cnt == CNT_W'(FRAME_BITS - 1) && !s.rw) begin
                    unique case (s.addr)
                        REG_DEMOD_PHASE_CODE: begin
                            // Only selected channels take the code [R4] [R5] [R13]
                            for (int c = 0; c < NUM_CH; c++) begin
                                if (s.chan_sel[c]) begin
                                    next_s.codes[c] = wr_data[PHASE_CODE_LSB +: CODE_W];
                                end
                            end
                        end
                        REG_CHAN_SEL: begin
                            next_s.chan_sel = wr_data;
                        end
                        REG_REF_SEL: begin
                            next_s.ref_ext = wr_data[REF_EXT_BIT]; // [R9]
                        end
                        default: begin
                            // Unmapped writes are dropped
                        end
                    endcase
                end
            end
            if (sclk_fall && s.rw && s.bit_cnt >= CNT_W'(INSTR_BITS)
                    && s.bit_cnt < CNT_W'(FRAME_BITS)) begin
                next_s.sdio    = s.shift[INSTR_BITS-1];
                next_s.sdio_oe = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // The sync pulse loads reset values into the whole block (codes to zero, chan_sel to all ones), so
    // software must reprogram codes after each pulse. Release lets the
    // first rising edge step the divider from its known count. [R7] [R10]
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s.div      <= DIV_RESET;                           // [R7]
            s.lo_i     <= 1'b0;
            s.lo_q     <= 1'b0;
            s.chan_i   <= '0;
            s.chan_q   <= '0;
            s.codes    <= {NUM_CH{CODE_RESET}};
            s.chan_sel <= CHAN_SEL_RESET;
            s.ref_ext  <= 1'b0;                                // [R9]
            s.sclk_q   <= 1'b0;
            s.bit_cnt  <= '0;
            s.shift    <= '0;
            s.rw       <= 1'b0;
            s.addr     <= '0;
            s.sdio     <= 1'b0;
            s.sdio_oe  <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        sdio_o    = s.sdio;
        sdio_oe_o = s.sdio_oe;
        lo_i_o    = s.lo_i;
        lo_q_o    = s.lo_q;
        chan_i_o  = s.chan_i;
        chan_q_o  = s.chan_q;
        ref_ext_o = s.ref_ext;
        for (int c = 0; c < NUM_CH; c++) begin
            chan_fine_o[c] = code_fine(s.codes[c]);
        end
    end

endmodule
`default_nettype wire

/* File: shared/qlops_pkg.sv */
// Purpose: Constants and types for the quadrature LO divider and phase select block.
// Assumes: ref_clk_i is the four-times-LO clock; sys_rst_i is the sync pulse.
// Notes:   Register offsets are serial-port byte addresses.
//
// How it works
// R1: Divide the 4x LO clock by four to make 0 and 90 degree LO phases.
// R2: Both LO phases are high two cycles, low two cycles: exact 50 percent duty.
// R3: LO outputs come straight from flip-flops clocked by the 4x LO clock.
// R4: Each channel has sixteen phase states, 22.5 degrees apart, set over serial port.
// R5: Rotation equals code in bits 3..0 of byte 0x2D times 22.5 degrees.
// R6: Equal codes give identical outputs; code plus one leads by one step.
// R7: RESET forces every divider into one known state, aligning all channels.
// R8: Controller sends one common RESET pulse to every device of an array.
// R9: Serial port picks internal reference (default, 2 V p-p) or external one.
// R10: After RESET falls, dividers count from the first following rising 4x edge.
// R11: Controller holds RESET at least 20 ns, releasing before a rising 4x edge; the bench's first pulse is 3 clocks, 15 ns.
// R12: Without RESET the divider may start in any of its four phase states.
// R13: A phase code write changes only its channels, never the divider.
package qlops_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int          NUM_CH      = 8;
    localparam int          CODE_W      = 4;
    localparam int          ADDR_W      = 13;
    localparam int          DATA_W      = 8;
    localparam int          INSTR_BITS  = 16;
    localparam int          FRAME_BITS  = 24;
    localparam int          CNT_W       = 5;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [12:0] REG_CHAN_SEL         = 13'h0005;
    localparam logic [12:0] REG_REF_SEL          = 13'h0018;
    localparam logic [12:0] REG_DEMOD_PHASE_CODE = 13'h002D;
    localparam int          PHASE_CODE_LSB       = 0;
    localparam int          QUAD_LSB             = 2;
    localparam int          REF_EXT_BIT          = 0;
    localparam int          INSTR_RW_BIT         = 15;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  CHAN_SEL_RESET = 8'hFF;
    localparam logic [3:0]  CODE_RESET     = 4'h0;
    localparam logic [1:0]  DIV_RESET      = 2'h0;
    localparam logic [7:0]  READ_NONE      = 8'h00;

    // ------------------------------------------------------------------
    // Timing of the sync pulse, held by the controller
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_PS    = 5000;
    localparam int          RESET_MIN_NS     = 20;
    localparam int          RESET_MIN_CYCLES =
        (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                     div;
        logic                           lo_i;
        logic                           lo_q;
        logic [NUM_CH-1:0]              chan_i;
        logic [NUM_CH-1:0]              chan_q;
        logic [NUM_CH-1:0][CODE_W-1:0]  codes;
        logic [NUM_CH-1:0]              chan_sel;
        logic                           ref_ext;
        logic                           sclk_q;
        logic [CNT_W-1:0]               bit_cnt;
        logic [INSTR_BITS-1:0]          shift;
        logic                           rw;
        logic [ADDR_W-1:0]              addr;
        logic                           sdio;
        logic                           sdio_oe;
    } qlops_state_t;

endpackage

/* File: verification/qlops_checker.sv */
// Purpose: Port-level assertions for the quadrature LO phase select block.
// Assumes: Codes and reference change only inside serial frames.
// Notes:   Rotation checks wait for two quiet cycles after a frame.
`timescale 1ns/1ps
`default_nettype none
module qlops_checker (
    input wire logic                                ref_clk_i,   // 4x LO clock
    input wire logic                                sys_rst_i,   // Sync pulse
    input wire logic                                csb_n_i,     // Serial select
    input wire logic                                sdio_oe_o,   // Drive enable
    input wire logic                                lo_i_o,      // 0 degree LO
    input wire logic                                lo_q_o,      // 90 degree LO
    input wire logic [qlops_pkg::NUM_CH-1:0]        chan_i_o,    // Rotated I
    input wire logic [qlops_pkg::NUM_CH-1:0]        chan_q_o,    // Rotated Q
    input wire logic [qlops_pkg::NUM_CH-1:0][1:0]   chan_fine_o, // Fine step
    input wire logic                                ref_ext_o    // External ref
);
    import qlops_pkg::*;
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    lo_q_duty_a: assert property ($rose(lo_q_o) |=> lo_q_o ##1 !lo_q_o [*2] ##1 lo_q_o)
        else $error("lo_q not two high two low");
    lo_i_duty_a: assert property ($fell(lo_i_o) |=> !lo_i_o ##1 lo_i_o [*2] ##1 !lo_i_o)
        else $error("lo_i not two high two low");
    lo_quadrature_a: assert property (lo_i_o == $past(lo_q_o))
        else $error("lo_q does not lead lo_i by one clock");
    resync_start_a: assert property ($fell(sys_rst_i) |=> !lo_i_o && lo_q_o)
        else $error("divider did not resume on first edge");
    reset_clear_a: assert property (disable iff (1'b0)
        sys_rst_i && $past(sys_rst_i) |-> !lo_i_o && !lo_q_o && chan_i_o == '0 && chan_q_o == '0)
        else $error("outputs not cleared by sync pulse");
    chan_rotation_a: assert property (csb_n_i && $past(csb_n_i) |-> chan_i_o == $past(chan_q_o))
        else $error("channel I and Q not in quadrature");
    fine_quiet_a: assert property (!$stable(chan_fine_o) |-> !$past(csb_n_i))
        else $error("fine code changed outside a frame");
    ref_quiet_a: assert property (!$stable(ref_ext_o) |-> !$past(csb_n_i))
        else $error("reference select changed outside a frame");
    oe_release_a: assert property (csb_n_i && $past(csb_n_i) |=> !sdio_oe_o)
        else $error("data pin still driven after frame");

    cover property ($rose(sdio_oe_o));
    cover property (!$stable(chan_fine_o));
    cover property ($fell(sys_rst_i));
endmodule
bind qlops_top qlops_checker u_chk (.ref_clk_i, .sys_rst_i, .csb_n_i, .sdio_oe_o, .lo_i_o,
    .lo_q_o, .chan_i_o, .chan_q_o, .chan_fine_o, .ref_ext_o);
`default_nettype wire

/* File: verification/qlops_ctrl_model.sv */
// Purpose: Timing controller model that drives the divider sync pulse.
// Assumes: One pulse output serves every device of the array.
// Notes:   Pulse edges land on falling clock edges for full setup margin.
`timescale 1ns/1ps
`default_nettype none
module qlops_ctrl_model (
    input  wire logic       clk_i,     // 4x LO clock
    input  wire logic       req_i,     // Ask for a pulse
    input  wire logic [7:0] hold_i,    // Pulse length in clocks
    output logic            sys_rst_o  // Common sync pulse
);
    logic rst_q = 1'b1;

    assign sys_rst_o = rst_q; // One pulse fans out to every device

    always begin
        if (rst_q) begin
            @(negedge clk_i);
            repeat (hold_i - 8'h01) @(negedge clk_i);
            rst_q = 1'b0; // Falling-edge release keeps setup before the next rise
        end
        @(posedge clk_i);
        if (req_i) begin
            @(negedge clk_i);
            rst_q = 1'b1; // Raise on a falling edge
        end
    end
endmodule
`default_nettype wire

/* File: verification/test_quadrature_lo_phase_select.sv */
// Purpose: Self-checking bench for the quadrature LO phase select block.
// Assumes: Serial frames use four reference clocks per SCLK period.
// Notes:   Bench model tracks divider phase, codes, channel mask and reference.
`timescale 1ns/1ps
`default_nettype none
module test_quadrature_lo_phase_select;
    import qlops_pkg::*;
    logic ref_clk = 1'b0;
    logic sclk = 1'b0;
    logic csb_n = 1'b1;
    logic host_d = 1'b0;
    logic host_oe = 1'b0;
    logic req = 1'b0;
    logic [7:0] hold = 8'h03;
    logic [7:0] rd;
    wire sys_rst, sdio_o, sdio_oe, lo_i, lo_q, ref_ext, sdio_w;
    wire [NUM_CH-1:0] chan_i, chan_q;
    wire [NUM_CH-1:0][1:0] chan_fine;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int ph = 0;
    int msel = 255;
    int mref = 0;
    int mcode [$] = '{0, 0, 0, 0, 0, 0, 0, 0};

    // Data pin has a pull-down, so a released line reads low
    assign sdio_w = sdio_oe ? sdio_o : (host_oe ? host_d : 1'b0);
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk or posedge sys_rst) ph <= sys_rst ? 0 : (ph + 1) % 4;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end

    qlops_ctrl_model ctrl (.clk_i(ref_clk), .req_i(req), .hold_i(hold), .sys_rst_o(sys_rst));
    qlops_top uut (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .sclk_i(sclk), .csb_n_i(csb_n),
        .sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe), .lo_i_o(lo_i), .lo_q_o(lo_q),
        .chan_i_o(chan_i), .chan_q_o(chan_q), .chan_fine_o(chan_fine), .ref_ext_o(ref_ext));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic spi(input logic rw, input logic [12:0] addr, input logic [7:0] wd);
        logic [23:0] frame;
        frame = {rw, 2'h0, addr, wd};
        csb_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sclk = 1'b0;
            host_d = frame[i];
            host_oe = !rw || i >= 8; // Host lets go of the pin for read data
            repeat (2) @(negedge ref_clk);
            sclk = 1'b1;
            repeat (2) @(negedge ref_clk);
            if (i < 8) rd[i] = sdio_w;
        end
        sclk = 1'b0;
        host_oe = 1'b0;
        repeat (2) @(negedge ref_clk);
        csb_n = 1'b1;
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic check_lo();
        int c;
        repeat (4) begin
            @(negedge ref_clk);
            check("lo", {6'h00, lo_i, lo_q}, 8'(ph ^ (ph >> 1)));
            foreach (mcode[n]) begin
                c = (ph + mcode[n] / 4) % 4;
                check("chan", {6'h00, chan_i[n], chan_q[n]}, 8'(c ^ (c >> 1)));
                check("fine", {6'h00, chan_fine[n]}, 8'(mcode[n] % 4));
            end
            check("ref", {7'h00, ref_ext}, 8'(mref));
        end
    endtask

    function automatic int low_code();
        for (int n = 0; n < NUM_CH; n++) if (msel[n]) return mcode[n];
        return 0;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(98053));
        wait (!sys_rst);
        spi(1'b1, REG_CHAN_SEL, 8'h00);
        check("sel", rd, CHAN_SEL_RESET);
        check_lo();
        $display("test defaults done");
        for (int k = 0; k < 16; k++) begin
            msel = $urandom % 256;
            spi(1'b0, REG_CHAN_SEL, 8'(msel));
            spi(1'b0, REG_DEMOD_PHASE_CODE, {4'($urandom), 4'(k)});
            foreach (mcode[n]) if (msel[n]) mcode[n] = k;
            check_lo();
            spi(1'b1, REG_DEMOD_PHASE_CODE, 8'h00);
            check("code", rd, 8'(low_code()));
        end
        $display("test phase codes done");
        spi(1'b0, REG_REF_SEL, 8'h01);
        mref = 1;
        spi(1'b1, REG_REF_SEL, 8'h00);
        check("ref_rd", rd, 8'h01);
        spi(1'b0, 13'h0123, 8'hA5);
        spi(1'b1, 13'h0123, 8'h00);
        check("unmapped", rd, READ_NONE);
        check_lo();
        $display("test reference done");
        hold = 8'h09;
        req = 1'b1;
        @(negedge ref_clk);
        req = 1'b0;
        wait (sys_rst);
        wait (!sys_rst);
        msel = 255;
        mref = 0;
        foreach (mcode[n]) mcode[n] = 0;
        check_lo();
        spi(1'b1, REG_CHAN_SEL, 8'h00);
        check("sel", rd, CHAN_SEL_RESET);
        $display("test resync done");
        results();
    end
endmodule
`default_nettype wire
